// >>> pkg/part_router_map.svh
// Purpose: offsets, field codes, reset values of the part router
// Assumes: four parts, 7-bit midi data
// Notes:   channels are stored as channel number minus one
// What this block does
// - each part holds channel 1-16, used for send and accept in performance mode
// - program mode sends local messages on the global channel only
// - program mode drops channel messages not on the global channel
// - program mode refuses part channel changes; part one stays the edited part
// - a part ignores notes below its lower limit, settable from C-2
// - a part ignores notes above its upper limit, settable up to G8
// - per-part semitone offset -24..+24 added to the oscillator offset
// - per-part fine offset -64..+63 cents added to oscillator fine offset
// - selectable velocity curve per part: normal, inverse, or doubling on the low or high half
// - curves also pass velocities only up to, or from, a threshold
// - stereo pair routing puts left on the odd jack, right on the even
// - single jack routing makes the part mono
// - all four parts route freely, sharing outputs allowed
// - pedal movement becomes the part's controller number 1..119
// - footswitch: off, sustain (reset default) or arpeggiator toggle
// - performance mode sends local messages on the edited part's channel
// - machine-wide controls always send on the global channel
// - machine-wide controls accepted on global, or in performance mode on any active part channel
// - in performance mode a part answers only its channel while active
// - in performance mode one message reaches every active part on the matching channel
// - in performance mode an inactive part neither accepts nor sends messages
`ifndef PART_ROUTER_MAP_SVH
`define PART_ROUTER_MAP_SVH
`define F_CHAN      4'h0
`define F_LOW       4'h1
`define F_HIGH      4'h2
`define F_SEMI      4'h3
`define F_CENT      4'h4
`define F_CURVE     4'h5
`define F_THRESH    4'h6
`define F_ROUTE     4'h7
`define F_PEDAL     4'h8
`define F_SWITCH    4'h9
`define NOTE_MIN    7'h00
`define NOTE_MAX    7'h7F
`define SEMI_MAX    8'h18
`define PEDAL_MAX   8'h77
`define CHAN_MAX    8'h10
`define VEL_MAX     7'h7F
`define VEL_HALF    7'h40
`define RST_CHAN    4'h0
`define RST_THRESH  7'h40
`define RST_PEDAL   7'h01
`define ST_NOTE_OFF 4'h8
`define ST_NOTE_ON  4'h9
`define ST_CC       4'hB
`define ST_SYSTEM   4'hF
`endif

// >>> pkg/part_router_pkg.sv
// Purpose: types shared by the part router files
// Assumes: nothing beyond the map header
// Notes:   encodings are internal to the block
package part_router_pkg;
    typedef enum logic [2:0] {
        CURVE_NORMAL, CURVE_INVERSE, CURVE_XLOW, CURVE_XHIGH,
        CURVE_UPTO, CURVE_FROM
    } curve_t;
    typedef enum logic [2:0] {
        ROUTE_PAIR12, ROUTE_PAIR34, ROUTE_J1, ROUTE_J2, ROUTE_J3, ROUTE_J4
    } route_t;
    typedef enum logic [1:0] {
        SW_OFF, SW_SUSTAIN, SW_ARP
    } switch_t;
endpackage

// >>> src/part_gate.sv
// Purpose: per-part accept test and velocity shaping
// Assumes: combinational, settings registered by the caller, message fields passed straight through
// Notes:   non-note channel messages skip range and velocity gates
`timescale 1ns/100ps
`include "part_router_map.svh"
module part_gate (
    input  wire logic                   perf_mode,
    input  wire logic                   first_part,
    input  wire logic                   active,
    input  wire logic [3:0]             chan,
    input  wire logic [3:0]             global_chan,
    input  wire logic [6:0]             low_note,
    input  wire logic [6:0]             high_note,
    input  wire part_router_pkg::curve_t curve,
    input  wire logic [6:0]             thresh,
    input  wire logic [7:0]             status,
    input  wire logic [6:0]             d1,
    input  wire logic [6:0]             d2,
    output logic                        hit,
    output logic [6:0]                  vel
);
    wire       is_note = (status[7:4] == `ST_NOTE_ON) || (status[7:4] == `ST_NOTE_OFF);
    wire       is_on   = (status[7:4] == `ST_NOTE_ON) && (d2 != 7'h00);
    // program mode: only part one plays, on the global channel
    wire       chan_ok = perf_mode ? (status[3:0] == chan) && active
                                   : first_part && (status[3:0] == global_chan);
    wire       range_ok = (d1 >= low_note) && (d1 <= high_note);
    wire [7:0] dbl = {d2, 1'b0};
    logic       vel_ok;
    // velocity switch curves reject note-ons outside their band
    always_comb
    begin
        vel    = d2;
        vel_ok = 1'b1;
        case (curve)
            part_router_pkg::CURVE_NORMAL:  vel = d2;
            part_router_pkg::CURVE_INVERSE: vel = `VEL_MAX - d2 + 7'h01;
            part_router_pkg::CURVE_XLOW:    vel = (d2 >= `VEL_HALF) ? `VEL_MAX : dbl[6:0];
            part_router_pkg::CURVE_XHIGH:   vel = (d2 < `VEL_HALF) ? 7'h01 : {dbl[6:1], 1'b1};
            part_router_pkg::CURVE_UPTO:    vel_ok = (d2 <= thresh);
            part_router_pkg::CURVE_FROM:    vel_ok = (d2 >= thresh);
            default:                        vel = d2;
        endcase
        if (!is_on)
        begin
            vel    = d2;
            vel_ok = 1'b1;
        end
    end
    assign hit = chan_ok && (!is_note || (range_ok && vel_ok));
endmodule

// >>> src/part_router.sv
// Purpose: midi channel routing, filtering and per-part settings, four parts
// Assumes: all inputs synchronous to clk; one message per cycle at most
// Notes:   settings written through a field port; outputs one cycle late
`timescale 1ns/100ps
`include "part_router_map.svh"
module part_router (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             perf_mode,
    input  wire logic [3:0]       global_chan,
    input  wire logic [3:0]       part_active,
    input  wire logic [1:0]       edit_part,
    input  wire logic             cfg_we,
    input  wire logic [1:0]       cfg_part,
    input  wire logic [3:0]       cfg_field,
    input  wire logic [7:0]       cfg_data,
    input  wire logic             rx_valid,
    input  wire logic             rx_machine,
    input  wire logic [7:0]       rx_status,
    input  wire logic [6:0]       rx_d1,
    input  wire logic [6:0]       rx_d2,
    input  wire logic             tx_req,
    input  wire logic             tx_machine,
    input  wire logic [3:0]       tx_kind,
    input  wire logic [6:0]       tx_d1,
    input  wire logic [6:0]       tx_d2,
    input  wire logic             pedal_valid,
    input  wire logic [6:0]       pedal_val,
    input  wire logic             footsw_down,
    input  wire logic [7:0]       osc_semi,
    input  wire logic [7:0]       osc_cent,
    output logic [3:0]            part_rx_ff,
    output logic [7:0]            rx_status_ff,
    output logic [6:0]            rx_d1_ff,
    output logic [6:0]            rx_d2_ff,
    output logic [3:0][6:0]       part_vel_ff,
    output logic                  machine_rx_ff,
    output logic                  tx_valid_ff,
    output logic [7:0]            tx_status_ff,
    output logic [6:0]            tx_d1_ff,
    output logic [6:0]            tx_d2_ff,
    output logic [3:0][7:0]       part_semi_ff,
    output logic [3:0][7:0]       part_cent_ff,
    output logic [3:0][2:0]       left_jack_ff,
    output logic [3:0][2:0]       right_jack_ff,
    output logic [3:0]            part_mono_ff,
    output logic [3:0]            pedal_hit_ff,
    output logic [3:0][6:0]       pedal_cc_ff,
    output logic [6:0]            pedal_val_ff,
    output logic [3:0]            sustain_ff,
    output logic [3:0]            arp_toggle_ff,
    output logic                  cfg_refused_ff
);
    // per-part settings
    logic [3:0][3:0]                chan_ff;
    logic [3:0][6:0]                low_ff;
    logic [3:0][6:0]                high_ff;
    logic [3:0][7:0]                semi_ff;
    logic [3:0][6:0]                cent_ff;
    part_router_pkg::curve_t [3:0]  curve_ff;
    logic [3:0][6:0]                thresh_ff;
    part_router_pkg::route_t [3:0]  route_ff;
    logic [3:0][6:0]                pedal_ff;
    part_router_pkg::switch_t [3:0] switch_ff;
    logic                           footsw_q_ff;

    // signed clamp test for the semitone field
    function automatic logic semi_legal(input logic [7:0] v);
        semi_legal = $signed(v) <= $signed(`SEMI_MAX) && $signed(v) >= -$signed(`SEMI_MAX);
    endfunction

    // jack numbers for a route: left/odd, right/even, or the single jack
    function automatic logic [2:0] jack_of(input part_router_pkg::route_t r,
                                           input logic right);
        case (r)
            part_router_pkg::ROUTE_PAIR12: jack_of = right ? 3'h2 : 3'h1;
            part_router_pkg::ROUTE_PAIR34: jack_of = right ? 3'h4 : 3'h3;
            part_router_pkg::ROUTE_J1:     jack_of = 3'h1;
            part_router_pkg::ROUTE_J2:     jack_of = 3'h2;
            part_router_pkg::ROUTE_J3:     jack_of = 3'h3;
            part_router_pkg::ROUTE_J4:     jack_of = 3'h4;
            default:                       jack_of = 3'h1;
        endcase
    endfunction

    // write decode and legality of the incoming value
    wire        wr_chan   = cfg_we && (cfg_field == `F_CHAN);
    wire        chan_ok   = (cfg_data != 8'h00) && (cfg_data <= `CHAN_MAX);
    wire        chan_take = wr_chan && perf_mode && chan_ok;
    wire        note_ok   = (cfg_data[7] == 1'b0);
    wire        pedal_ok  = (cfg_data != 8'h00) && (cfg_data <= `PEDAL_MAX);
    wire        curve_ok  = (cfg_data <= 8'h05);
    wire        route_ok  = (cfg_data <= 8'h05);
    wire        sw_ok     = (cfg_data <= 8'h02);
    wire        cent_ok   = (cfg_data[7] == cfg_data[6]);
    wire [3:0]  chan_val  = 4'(cfg_data - 8'h01);
    logic       field_ok;

    // pick the legality test of the addressed field
    always_comb
    begin
        case (cfg_field)
            `F_CHAN:   field_ok = chan_take;
            `F_LOW:    field_ok = note_ok;
            `F_HIGH:   field_ok = note_ok;
            `F_SEMI:   field_ok = semi_legal(cfg_data);
            `F_CENT:   field_ok = cent_ok;
            `F_CURVE:  field_ok = curve_ok;
            `F_THRESH: field_ok = note_ok;
            `F_ROUTE:  field_ok = route_ok;
            `F_PEDAL:  field_ok = pedal_ok;
            `F_SWITCH: field_ok = sw_ok;
            default:   field_ok = 1'b0;
        endcase
    end

    // settings store; illegal values leave the old value in place
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int p = 0; p < 4; p++)
            begin
                chan_ff[p]   <= `RST_CHAN;
                low_ff[p]    <= `NOTE_MIN;
                high_ff[p]   <= `NOTE_MAX;
                semi_ff[p]   <= 8'h00;
                cent_ff[p]   <= 7'h00;
                curve_ff[p]  <= part_router_pkg::CURVE_NORMAL;
                thresh_ff[p] <= `RST_THRESH;
                route_ff[p]  <= part_router_pkg::ROUTE_PAIR12;
                pedal_ff[p]  <= `RST_PEDAL;
                switch_ff[p] <= part_router_pkg::SW_SUSTAIN;
            end
        end
        else if (cfg_we && field_ok)
        begin
            case (cfg_field)
                `F_CHAN:   chan_ff[cfg_part]   <= chan_val;
                `F_LOW:    low_ff[cfg_part]    <= cfg_data[6:0];
                `F_HIGH:   high_ff[cfg_part]   <= cfg_data[6:0];
                `F_SEMI:   semi_ff[cfg_part]   <= cfg_data;
                `F_CENT:   cent_ff[cfg_part]   <= cfg_data[6:0];
                `F_CURVE:  curve_ff[cfg_part]  <= part_router_pkg::curve_t'(cfg_data[2:0]);
                `F_THRESH: thresh_ff[cfg_part] <= cfg_data[6:0];
                `F_ROUTE:  route_ff[cfg_part]  <= part_router_pkg::route_t'(cfg_data[2:0]);
                `F_PEDAL:  pedal_ff[cfg_part]  <= cfg_data[6:0];
                `F_SWITCH: switch_ff[cfg_part] <= part_router_pkg::switch_t'(cfg_data[1:0]);
                default:   pedal_ff[cfg_part]  <= pedal_ff[cfg_part];
            endcase
        end
    end

    // receive side: one gate per part, all may hit together
    logic [3:0]      gate_hit;
    logic [3:0][6:0] gate_vel;
    for (genvar g = 0; g < 4; g++)
    begin : gen_gate
        part_gate u_gate (
            .perf_mode   (perf_mode),
            .first_part  (g == 0),
            .active      (part_active[g]),
            .chan        (chan_ff[g]),
            .global_chan (global_chan),
            .low_note    (low_ff[g]),
            .high_note   (high_ff[g]),
            .curve       (curve_ff[g]),
            .thresh      (thresh_ff[g]),
            .status      (rx_status),
            .d1          (rx_d1),
            .d2          (rx_d2),
            .hit         (gate_hit[g]),
            .vel         (gate_vel[g])
        );
    end

    // machine-wide controls: global channel, or any active part in perf mode
    wire        rx_system = (rx_status[7:4] == `ST_SYSTEM);
    wire [3:0]  part_chan_hit;
    for (genvar c = 0; c < 4; c++)
    begin : gen_chan
        assign part_chan_hit[c] = part_active[c] && (chan_ff[c] == rx_status[3:0]);
    end
    wire        on_global  = (rx_status[3:0] == global_chan);
    wire        mach_ok    = on_global || (perf_mode && (|part_chan_hit));
    wire        nxt_mach   = rx_valid && rx_machine && !rx_system && mach_ok;
    wire [3:0]  nxt_rx     = (rx_valid && !rx_machine && !rx_system) ? gate_hit : 4'h0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            part_rx_ff    <= 4'h0;
            machine_rx_ff <= 1'b0;
            rx_status_ff  <= 8'h00;
            rx_d1_ff      <= 7'h00;
            rx_d2_ff      <= 7'h00;
            part_vel_ff   <= '0;
        end
        else
        begin
            part_rx_ff    <= nxt_rx;
            machine_rx_ff <= nxt_mach;
            rx_status_ff  <= rx_status;
            rx_d1_ff      <= rx_d1;
            rx_d2_ff      <= rx_d2;
            part_vel_ff   <= gate_vel;
        end
    end

    // transmit side: program mode pins editing to part one
    wire [1:0]  eff_edit   = perf_mode ? edit_part : 2'h0;
    wire        edit_live  = !perf_mode || part_active[eff_edit];
    wire [3:0]  part_chan  = perf_mode ? chan_ff[eff_edit] : global_chan;
    wire [3:0]  tx_chan    = tx_machine ? global_chan : part_chan;
    wire        tx_go      = tx_req && (tx_machine || edit_live);
    // pedal shares the sender; an explicit request in the same cycle wins
    wire        pedal_go   = pedal_valid && !tx_req && edit_live;
    wire        nxt_tx     = tx_go || pedal_go;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_valid_ff  <= 1'b0;
            tx_status_ff <= 8'h00;
            tx_d1_ff     <= 7'h00;
            tx_d2_ff     <= 7'h00;
        end
        else
        begin
            tx_valid_ff  <= nxt_tx;
            tx_status_ff <= tx_req ? {tx_kind, tx_chan} : {`ST_CC, part_chan};
            tx_d1_ff     <= tx_req ? tx_d1 : pedal_ff[eff_edit];
            tx_d2_ff     <= tx_req ? tx_d2 : pedal_val;
        end
    end

    // parts that hear the pedal and footswitch locally
    wire [3:0]  local_part = perf_mode ? part_active : 4'h1;
    wire        fsw_rise   = footsw_down && !footsw_q_ff;
    logic [3:0] nxt_sus;
    logic [3:0] nxt_arp;
    always_comb
    begin
        for (int s = 0; s < 4; s++)
        begin
            nxt_sus[s] = local_part[s] && footsw_down
                         && (switch_ff[s] == part_router_pkg::SW_SUSTAIN);
            nxt_arp[s] = local_part[s] && fsw_rise
                         && (switch_ff[s] == part_router_pkg::SW_ARP);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            footsw_q_ff   <= 1'b0;
            sustain_ff    <= 4'h0;
            arp_toggle_ff <= 4'h0;
            pedal_hit_ff  <= 4'h0;
            pedal_cc_ff   <= '0;
            pedal_val_ff  <= 7'h00;
        end
        else
        begin
            footsw_q_ff   <= footsw_down;
            sustain_ff    <= nxt_sus;
            arp_toggle_ff <= nxt_arp;
            pedal_hit_ff  <= pedal_valid ? local_part : 4'h0;
            pedal_cc_ff   <= pedal_ff;
            pedal_val_ff  <= pedal_val;
        end
    end

    // tuning sums and output routing, each part independent
    logic [3:0][7:0] nxt_semi;
    logic [3:0][7:0] nxt_cent;
    always_comb
    begin
        for (int t = 0; t < 4; t++)
        begin
            nxt_semi[t] = semi_ff[t] + osc_semi;
            nxt_cent[t] = {cent_ff[t][6], cent_ff[t]} + osc_cent;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            part_semi_ff   <= '0;
            part_cent_ff   <= '0;
            left_jack_ff   <= '0;
            right_jack_ff  <= '0;
            part_mono_ff   <= 4'h0;
            cfg_refused_ff <= 1'b0;
        end
        else
        begin
            part_semi_ff   <= nxt_semi;
            part_cent_ff   <= nxt_cent;
            cfg_refused_ff <= cfg_we && !field_ok;
            for (int j = 0; j < 4; j++)
            begin
                left_jack_ff[j]  <= jack_of(route_ff[j], 1'b0);
                right_jack_ff[j] <= jack_of(route_ff[j], 1'b1);
                part_mono_ff[j]  <= (route_ff[j] != part_router_pkg::ROUTE_PAIR12)
                                 && (route_ff[j] != part_router_pkg::ROUTE_PAIR34);
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_prog_rx;
        !perf_mode && rx_valid && !rx_machine && !rx_system;
    endsequence

    a_prog_chan_lock: assert property (
        wr_chan && !perf_mode |=> $stable(chan_ff) && cfg_refused_ff)
        else $error("channel changed in program mode");
    a_prog_rx_filter: assert property (
        s_prog_rx ##0 (rx_status[3:0] != global_chan) |=> part_rx_ff == 4'h0)
        else $error("off-channel message accepted in program mode");
    a_muted_no_rx: assert property (
        perf_mode && rx_valid |=> (part_rx_ff & ~$past(part_active)) == 4'h0)
        else $error("inactive part received a message");
    a_range_gate: assert property (
        rx_valid && rx_status[7:4] == `ST_NOTE_ON && rx_d1 < low_ff[0]
        |=> !part_rx_ff[0])
        else $error("note below lower limit reached part");
    a_high_gate: assert property (
        rx_valid && rx_status[7:4] == `ST_NOTE_ON && rx_d1 > high_ff[1]
        |=> !part_rx_ff[1])
        else $error("note above upper limit reached part");
    a_tx_global: assert property (
        tx_req && (!perf_mode || tx_machine) |=> tx_valid_ff && tx_status_ff[3:0] == $past(global_chan))
        else $error("wrong channel on send");
    a_tx_edit_chan: assert property (
        tx_req && perf_mode && !tx_machine && part_active[edit_part]
        |=> tx_valid_ff && tx_status_ff[3:0] == $past(chan_ff[edit_part]))
        else $error("send not on edited part channel");
    a_tx_muted: assert property (
        tx_req && perf_mode && !tx_machine && !part_active[edit_part] |=> !tx_valid_ff)
        else $error("muted part sent a message");
    a_pair_stereo: assert property (
        route_ff[2] == part_router_pkg::ROUTE_PAIR34 [*2]
        |-> left_jack_ff[2] == 3'h3 && right_jack_ff[2] == 3'h4 && !part_mono_ff[2])
        else $error("stereo pair jacks wrong");
    a_pedal_cc: assert property (
        pedal_valid && !tx_req && !perf_mode |=> tx_valid_ff && tx_d1_ff != 7'h00)
        else $error("pedal controller not sent");
endmodule

// >>> tb/midi_seq_model.sv
// Purpose: sequencer side, sends channel messages into the router
// Assumes: caller stands just after a rising clk edge
// Notes:   released lines show the inverted last value
`timescale 1ns/100ps
module midi_seq_model (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic            rx_machine,
    output logic [7:0]      rx_status,
    output logic [6:0]      rx_d1,
    output logic [6:0]      rx_d2
);
    // idle until the first message
    initial
    begin
        {rx_valid, rx_machine, rx_status, rx_d1, rx_d2} = '0;
    end
    // idle edge first, so valid never falls and rises in one time step;
    // held over one sampling edge, then scrambled so stale data never matches
    task automatic send(input logic [7:0] st, input logic [6:0] a, input logic m);
    begin
        @(posedge clk);
        #1;
        {rx_valid, rx_machine, rx_status, rx_d1, rx_d2} = {1'b1, m, st, a, 7'h64};
        @(posedge clk);
        #1;
        {rx_valid, rx_machine, rx_status, rx_d1, rx_d2} = {1'b0, ~m, ~st, ~a, 7'h1B};
    end
    endtask
endmodule

// >>> tb/part_router_test.sv
// Purpose: self-checking bench for the part router
// Assumes: one message or write per call, all driven 1 ns after the edge
// Notes:   registered outputs are checked one edge after the request
`timescale 1ns/100ps
module part_router_test;
    logic clk = 1'b0, arst_n = 1'b0, perf_mode = 1'b1, cfg_we = 1'b0;
    logic tx_req = 1'b0, tx_machine = 1'b0, pedal_valid = 1'b0, footsw_down = 1'b0;
    logic [3:0] global_chan = 4'h0, part_active = 4'h7, cfg_field = 4'h0, tx_kind = 4'h0;
    logic [1:0] edit_part = 2'h0, cfg_part = 2'h0;
    logic [7:0] cfg_data = 8'h00, osc_semi = 8'h03, osc_cent = 8'h01;
    logic [6:0] tx_d1 = 7'h3C, tx_d2 = 7'h40, pedal_val = 7'h22;
    logic rx_valid, rx_machine, machine_rx_ff, tx_valid_ff, cfg_refused_ff;
    logic [7:0] rx_status, rx_status_ff, tx_status_ff;
    logic [6:0] rx_d1, rx_d2, rx_d1_ff, rx_d2_ff, tx_d1_ff, tx_d2_ff, pedal_val_ff;
    logic [3:0] part_rx_ff, part_mono_ff, pedal_hit_ff, sustain_ff, arp_toggle_ff;
    logic [3:0][6:0] part_vel_ff, pedal_cc_ff;
    logic [3:0][7:0] part_semi_ff, part_cent_ff;
    logic [3:0][2:0] left_jack_ff, right_jack_ff;
    int fail_count = 0, checked = 0, cycles = 0;

    part_router part_router_inst (.clk, .arst_n, .perf_mode, .global_chan, .part_active,
        .edit_part, .cfg_we, .cfg_part, .cfg_field, .cfg_data, .rx_valid, .rx_machine,
        .rx_status, .rx_d1, .rx_d2, .tx_req, .tx_machine, .tx_kind, .tx_d1, .tx_d2,
        .pedal_valid, .pedal_val, .footsw_down, .osc_semi, .osc_cent, .part_rx_ff,
        .rx_status_ff, .rx_d1_ff, .rx_d2_ff, .part_vel_ff, .machine_rx_ff, .tx_valid_ff,
        .tx_status_ff, .tx_d1_ff, .tx_d2_ff, .part_semi_ff, .part_cent_ff, .left_jack_ff,
        .right_jack_ff, .part_mono_ff, .pedal_hit_ff, .pedal_cc_ff, .pedal_val_ff,
        .sustain_ff, .arp_toggle_ff, .cfg_refused_ff);
    midi_seq_model midi_seq_model_inst (.clk, .rx_valid, .rx_machine, .rx_status,
        .rx_d1, .rx_d2);

    // 40 MHz clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report;
    begin
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task automatic step;
    begin
        @(posedge clk);
        #1;
    end
    endtask
    // settings write: an idle edge, then the strobe for one edge
    task automatic cfg(input logic [1:0] p, input logic [3:0] f, input logic [7:0] d);
    begin
        step();
        {cfg_we, cfg_part, cfg_field, cfg_data} = {1'b1, p, f, d};
        step();
        cfg_we = 1'b0;
    end
    endtask
    task automatic local_send(input logic [3:0] k, input logic m);
    begin
        step();
        {tx_req, tx_kind, tx_machine} = {1'b1, k, m};
        step();
        tx_req = 1'b0;
    end
    endtask
    task automatic rx_parts(input logic [7:0] st, input logic [6:0] n, input logic [3:0] e);
    begin
        midi_seq_model_inst.send(st, n, 1'b0);
        chk(part_rx_ff, e);
    end
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        arst_n = 1'b1;
        step();
        chk(left_jack_ff[0], 8'h01);
        chk(right_jack_ff[0], 8'h02);
        chk(part_semi_ff[0], 8'h03);
        // channels 3,3,5,3; part 3 muted
        cfg(2'h0, 4'h0, 8'h03);
        cfg(2'h1, 4'h0, 8'h03);
        cfg(2'h2, 4'h0, 8'h05);
        cfg(2'h3, 4'h0, 8'h03);
        rx_parts(8'h92, 7'h00, 4'h3);
        rx_parts(8'h92, 7'h7F, 4'h3);
        chk(part_vel_ff[0], 8'h64);
        // split: part 0 from 50 up, part 1 up to 45
        cfg(2'h0, 4'h1, 8'h32);
        cfg(2'h1, 4'h2, 8'h2D);
        rx_parts(8'h92, 7'h28, 4'h2);
        rx_parts(8'h92, 7'h3C, 4'h1);
        cfg(2'h0, 4'h5, 8'h01);
        rx_parts(8'h92, 7'h3C, 4'h1);
        chk(part_vel_ff[0], 8'h1C);
        cfg(2'h0, 4'h3, 8'h05);
        cfg(2'h0, 4'h4, 8'hC0);
        cfg(2'h0, 4'h3, 8'h19);
        chk(cfg_refused_ff, 8'h01);
        chk(part_semi_ff[0], 8'h08);
        chk(part_cent_ff[0], 8'hC1);
        // two parts share a pair, one goes mono
        cfg(2'h2, 4'h7, 8'h01);
        cfg(2'h3, 4'h7, 8'h01);
        cfg(2'h1, 4'h7, 8'h03);
        step();
        chk(left_jack_ff[2], 8'h03);
        chk(right_jack_ff[3], 8'h04);
        chk(left_jack_ff[1], 8'h02);
        chk(part_mono_ff, 8'h02);
        cfg(2'h0, 4'h8, 8'h78);
        chk(cfg_refused_ff, 8'h01);
        cfg(2'h0, 4'h8, 8'h69);
        edit_part = 2'h2;
        local_send(4'h9, 1'b0);
        chk(tx_status_ff, 8'h94);
        chk(tx_valid_ff, 8'h01);
        local_send(4'hB, 1'b1);
        chk(tx_status_ff, 8'hB0);
        edit_part = 2'h3;
        local_send(4'h9, 1'b0);
        chk(tx_valid_ff, 8'h00);
        midi_seq_model_inst.send(8'hB4, 7'h07, 1'b1);
        chk(machine_rx_ff, 8'h01);
        midi_seq_model_inst.send(8'hB7, 7'h07, 1'b1);
        chk(machine_rx_ff, 8'h00);
        // program mode on global channel 7
        perf_mode = 1'b0;
        global_chan = 4'h6;
        step();
        rx_parts(8'h96, 7'h3C, 4'h1);
        rx_parts(8'h92, 7'h3C, 4'h0);
        // velocity switch: up to 64 drops velocity 100, from 64 keeps it
        cfg(2'h0, 4'h5, 8'h04);
        rx_parts(8'h96, 7'h3C, 4'h0);
        cfg(2'h0, 4'h5, 8'h05);
        rx_parts(8'h96, 7'h3C, 4'h1);
        chk(part_vel_ff[0], 8'h64);
        chk(rx_d1_ff, 8'h3C);
        chk(rx_status_ff, 8'h96);
        cfg(2'h1, 4'h0, 8'h04);
        chk(cfg_refused_ff, 8'h01);
        local_send(4'h9, 1'b0);
        chk(tx_status_ff, 8'h96);
        pedal_valid = 1'b1;
        step();
        pedal_valid = 1'b0;
        chk(tx_status_ff, 8'hB6);
        chk(tx_d1_ff, 8'h69);
        chk(tx_d2_ff, 8'h22);
        chk(tx_valid_ff, 8'h01);
        chk(pedal_hit_ff, 8'h01);
        chk(pedal_cc_ff[0], 8'h69);
        chk(pedal_val_ff, 8'h22);
        footsw_down = 1'b1;
        step();
        step();
        chk(sustain_ff[0], 8'h01);
        // arpeggiator toggle pulses once on a fresh press
        footsw_down = 1'b0;
        cfg(2'h0, 4'h9, 8'h02);
        footsw_down = 1'b1;
        step();
        chk(arp_toggle_ff[0], 8'h01);
        chk(sustain_ff[0], 8'h00);
        final_report();
    end
endmodule
